// >>> rtl/timer16_pkg.sv
// constants and types shared by the timer16 waveform mode control block
package timer16_pkg;
   // ----------------------------------------------------------------
   // register offsets (byte addresses on the apb bus)
   // ----------------------------------------------------------------
   localparam int unsigned ADDR_W = 8;
   localparam logic [7:0] OFS_CTRL_A = 8'h00;
   localparam logic [7:0] OFS_CTRL_B = 8'h04;
   localparam logic [7:0] OFS_CMP_A = 8'h08;
   localparam logic [7:0] OFS_CMP_B = 8'h0C;
   localparam logic [7:0] OFS_CAPTURE = 8'h10;
   localparam logic [7:0] OFS_COUNT = 8'h14;
   localparam logic [7:0] OFS_STATUS = 8'h18;
   localparam logic [7:0] OFS_PIN_DIR = 8'h1C;
   // ----------------------------------------------------------------
   // field layout and reset values
   // ----------------------------------------------------------------
   localparam int unsigned CNT_W = 16;
   localparam int unsigned CTRL_A_W = 8;
   localparam int unsigned MODE_HI_MSB = 4;
   localparam int unsigned MODE_HI_LSB = 3;
   localparam int unsigned STAT_OVF_BIT = 0;
   localparam int unsigned STAT_DOWN_BIT = 1;
   localparam int unsigned DIR_A_BIT = 0;
   localparam int unsigned DIR_B_BIT = 1;
   localparam logic [7:0] CTRL_A_RESET = 8'h00;
   localparam logic [15:0] CNT_RESET = 16'h0000;
   localparam logic [15:0] CNT_STEP = 16'h0001;
   localparam logic [15:0] BOTTOM = 16'h0000;
   localparam logic [15:0] TOP_MAX = 16'hFFFF;
   localparam logic [15:0] TOP_8BIT = 16'h00FF;
   localparam logic [15:0] TOP_9BIT = 16'h01FF;
   localparam logic [15:0] TOP_10BIT = 16'h03FF;
   localparam logic [1:0] ACT_TOGGLE = 2'b01;
   // ----------------------------------------------------------------
   // mode classes, bit n set means waveform mode n belongs to the class
   // ----------------------------------------------------------------
   localparam logic [15:0] MODES_NONPWM = 16'h1011;
   localparam logic [15:0] MODES_FAST = 16'hC0E0;
   localparam logic [15:0] MODES_DUAL = 16'h0F0E;
   localparam logic [15:0] MODES_RELOAD_BOTTOM = 16'h0300;
   localparam logic [15:0] MODES_TOGGLE_A_PWM = 16'hCF00;
   localparam logic [15:0] MODES_TOP_CMP_A = 16'h8A10;
   localparam logic [15:0] MODES_TOP_CAPTURE = 16'h5500;
   localparam logic [15:0] MODES_TOP_8BIT = 16'h0022;
   localparam logic [15:0] MODES_TOP_9BIT = 16'h0044;
   localparam logic [15:0] MODES_TOP_10BIT = 16'h0088;
   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [1:0] act_a;
      logic [1:0] act_b;
      logic [1:0] rsvd;
      logic [1:0] mode_lo;
   } ctrl_a_s;
   typedef enum logic [1:0] {
      DIR_UP = 2'b01,
      DIR_DOWN = 2'b10
   } count_dir_e;
endpackage

// >>> rtl/timer16_waveform_mode_control.sv
// timer16 waveform mode control: counter sequencing, compare reload and compare outputs
`timescale 1ns/1ns
`default_nettype none
module timer16_waveform_mode_control (
   // apb clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb request
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [timer16_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   // apb answer
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // compare output pins
   output logic chan_a_wave_output,
   output logic chan_a_wave_oe,
   output logic chan_b_wave_output,
   output logic chan_b_wave_oe
);
   import timer16_pkg::*;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   ctrl_a_s ctrl_a_ff;
   logic [1:0] mode_hi_ff;
   logic [15:0] cmp_a_buf_ff, cmp_b_buf_ff, cmp_a_ff, cmp_b_ff, cap_ff, cnt_ff;
   logic ovf_ff;
   logic [1:0] pin_dir_ff;
   count_dir_e dir_ff;
   logic [3:0] mode;
   logic [15:0] top;
   logic access, wr_en, addr_ok;
   logic at_top, at_bottom, ovf_set, reload, match_a, match_b;
   logic [15:0] nxt_cnt;
   count_dir_e nxt_dir;
   logic [31:0] nxt_rdata;
   logic conn_a, conn_b, tog_a;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [15:0] top_of(input logic [3:0] m, input logic [15:0] ca,
                                           input logic [15:0] cap);
      logic [15:0] t;
      t = TOP_MAX;
      if (MODES_TOP_8BIT[m]) t = TOP_8BIT;
      if (MODES_TOP_9BIT[m]) t = TOP_9BIT;
      if (MODES_TOP_10BIT[m]) t = TOP_10BIT;
      if (MODES_TOP_CMP_A[m]) t = ca;
      if (MODES_TOP_CAPTURE[m]) t = cap;
      return t;
   endfunction

   // next compare output level for one channel
   function automatic logic wave_next(input logic cur, input logic [1:0] act,
                                      input logic [3:0] m, input logic match,
                                      input logic top_hit, input logic down,
                                      input logic tog_ok);
      logic v;
      v = cur;
      if (MODES_NONPWM[m]) begin
         if (match && act != 2'b00) v = (act == ACT_TOGGLE) ? ~cur : act[0];
      end else if (MODES_FAST[m]) begin
         if (act[1] && top_hit) v = ~act[0];
         else if (act[1] && match) v = act[0];
         else if (act == ACT_TOGGLE && tog_ok && match) v = ~cur;
      end else if (MODES_DUAL[m]) begin
         if (act[1] && match) v = down ? ~act[0] : act[0];
         else if (act == ACT_TOGGLE && tog_ok && match) v = ~cur;
      end
      return v;
   endfunction

   // ----------------------------------------------------------------
   // mode decode and counter sequencing
   // ----------------------------------------------------------------
   assign mode = {mode_hi_ff, ctrl_a_ff.mode_lo};
   assign top = top_of(mode, cmp_a_ff, cap_ff);
   assign match_a = (cnt_ff == cmp_a_ff);
   assign match_b = (cnt_ff == cmp_b_ff);
   assign tog_a = MODES_TOGGLE_A_PWM[mode];
   assign conn_a = ctrl_a_ff.act_a[1] | (ctrl_a_ff.act_a[0] & (MODES_NONPWM[mode] | tog_a));
   assign conn_b = ctrl_a_ff.act_b[1] | (ctrl_a_ff.act_b[0] & MODES_NONPWM[mode]);

   // next count, direction, top/bottom events
   always_comb begin
      nxt_cnt = cnt_ff;
      nxt_dir = dir_ff;
      at_top = 1'b0;
      at_bottom = 1'b0;
      ovf_set = 1'b0;
      reload = MODES_NONPWM[mode];
      if (MODES_DUAL[mode]) begin
         if (dir_ff == DIR_UP) begin
            at_top = (cnt_ff >= top);
            nxt_dir = at_top ? DIR_DOWN : DIR_UP;
            nxt_cnt = at_top ? cnt_ff - CNT_STEP : cnt_ff + CNT_STEP;
         end else begin
            at_bottom = (cnt_ff == BOTTOM);
            nxt_dir = at_bottom ? DIR_UP : DIR_DOWN;
            nxt_cnt = at_bottom ? cnt_ff + CNT_STEP : cnt_ff - CNT_STEP;
         end
         ovf_set = at_bottom;
         reload = MODES_RELOAD_BOTTOM[mode] ? at_bottom : at_top;
      end else if (MODES_FAST[mode] || MODES_NONPWM[mode]) begin
         at_top = (cnt_ff == top);
         nxt_dir = DIR_UP;
         nxt_cnt = at_top ? BOTTOM : cnt_ff + CNT_STEP;
         if (MODES_FAST[mode]) begin
            ovf_set = at_top;
            reload = at_top;
         end else begin
            ovf_set = (cnt_ff == TOP_MAX);
         end
      end
   end

   // ----------------------------------------------------------------
   // apb slave
   // ----------------------------------------------------------------
   assign access = psel & penable & ~pready;
   assign wr_en = access & pwrite;
   assign addr_ok = paddr inside {OFS_CTRL_A, OFS_CTRL_B, OFS_CMP_A, OFS_CMP_B,
                                  OFS_CAPTURE, OFS_COUNT, OFS_STATUS, OFS_PIN_DIR};

   // read mux
   always_comb begin
      nxt_rdata = 32'h0000_0000;
      unique case (paddr)
         OFS_CTRL_A: nxt_rdata[CTRL_A_W-1:0] = ctrl_a_ff;
         OFS_CTRL_B: nxt_rdata[MODE_HI_MSB:MODE_HI_LSB] = mode_hi_ff;
         OFS_CMP_A: nxt_rdata[CNT_W-1:0] = cmp_a_buf_ff;
         OFS_CMP_B: nxt_rdata[CNT_W-1:0] = cmp_b_buf_ff;
         OFS_CAPTURE: nxt_rdata[CNT_W-1:0] = cap_ff;
         OFS_COUNT: nxt_rdata[CNT_W-1:0] = cnt_ff;
         OFS_STATUS: begin
            nxt_rdata[STAT_OVF_BIT] = ovf_ff;
            nxt_rdata[STAT_DOWN_BIT] = (dir_ff == DIR_DOWN);
         end
         OFS_PIN_DIR: nxt_rdata[1:0] = pin_dir_ff;
         default: nxt_rdata = 32'h0000_0000;
      endcase
   end

   // answer one cycle into the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= access;
         pslverr <= access & ~addr_ok;
         prdata <= (access && !pwrite) ? nxt_rdata : 32'h0000_0000;
      end
   end

   // control registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_a_ff <= ctrl_a_s'(CTRL_A_RESET);
         mode_hi_ff <= 2'b00;
         pin_dir_ff <= 2'b00;
         cap_ff <= CNT_RESET;
      end else if (wr_en) begin
         if (paddr == OFS_CTRL_A) begin
            ctrl_a_ff <= ctrl_a_s'(pwdata[CTRL_A_W-1:0]);
            ctrl_a_ff.rsvd <= 2'b00;
         end
         if (paddr == OFS_CTRL_B) mode_hi_ff <= pwdata[MODE_HI_MSB:MODE_HI_LSB];
         if (paddr == OFS_PIN_DIR) pin_dir_ff <= pwdata[1:0];
         if (paddr == OFS_CAPTURE) cap_ff <= pwdata[CNT_W-1:0];
      end
   end

   // compare buffers and active compare values
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmp_a_buf_ff <= CNT_RESET;
         cmp_b_buf_ff <= CNT_RESET;
         cmp_a_ff <= CNT_RESET;
         cmp_b_ff <= CNT_RESET;
      end else begin
         if (wr_en && paddr == OFS_CMP_A) cmp_a_buf_ff <= pwdata[CNT_W-1:0];
         if (wr_en && paddr == OFS_CMP_B) cmp_b_buf_ff <= pwdata[CNT_W-1:0];
         if (reload) begin
            cmp_a_ff <= cmp_a_buf_ff;
            cmp_b_ff <= cmp_b_buf_ff;
         end
      end
   end

   // counter, direction and overflow flag (set wins over clear)
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_ff <= CNT_RESET;
         dir_ff <= DIR_UP;
         ovf_ff <= 1'b0;
      end else begin
         cnt_ff <= (wr_en && paddr == OFS_COUNT) ? pwdata[CNT_W-1:0] : nxt_cnt;
         dir_ff <= nxt_dir;
         if (ovf_set) ovf_ff <= 1'b1;
         else if (wr_en && paddr == OFS_STATUS && pwdata[STAT_OVF_BIT]) ovf_ff <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // compare outputs and pin drivers
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chan_a_wave_output <= 1'b0;
         chan_b_wave_output <= 1'b0;
         chan_a_wave_oe <= 1'b0;
         chan_b_wave_oe <= 1'b0;
      end else begin
         chan_a_wave_output <= wave_next(chan_a_wave_output, ctrl_a_ff.act_a, mode, match_a,
                                         at_top, dir_ff == DIR_DOWN, tog_a);
         chan_b_wave_output <= wave_next(chan_b_wave_output, ctrl_a_ff.act_b, mode, match_b,
                                         at_top, dir_ff == DIR_DOWN, 1'b0);
         chan_a_wave_oe <= conn_a & pin_dir_ff[DIR_A_BIT];
         chan_b_wave_oe <= conn_b & pin_dir_ff[DIR_B_BIT];
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   property p_rsvd_read_zero;
      access && !pwrite && paddr == OFS_CTRL_A |=> pready && prdata[3:2] == 2'b00;
   endproperty
   a_rsvd_read_zero: assert property (p_rsvd_read_zero) else $error("reserved bits nonzero");

   property p_oe_needs_dir;
      chan_a_wave_oe |-> $past(pin_dir_ff[DIR_A_BIT]);
   endproperty
   a_oe_needs_dir: assert property (p_oe_needs_dir) else $error("oe without direction");

   property p_off_no_oe;
      ctrl_a_ff.act_a == 2'b00 |=> !chan_a_wave_oe;
   endproperty
   a_off_no_oe: assert property (p_off_no_oe) else $error("pin taken while off");

   property p_fast_b_toggle_off;
      MODES_FAST[mode] && ctrl_a_ff.act_b == 2'b01 |=> !chan_b_wave_oe;
   endproperty
   a_fast_b_toggle_off: assert property (p_fast_b_toggle_off) else $error("b connected");

   property p_ctc_wrap;
      mode == 4'd4 && match_a && !wr_en |=> cnt_ff == BOTTOM;
   endproperty
   a_ctc_wrap: assert property (p_ctc_wrap) else $error("ctc did not clear");

   property p_ovf_at_max;
      MODES_NONPWM[mode] && cnt_ff == TOP_MAX |=> ovf_ff;
   endproperty
   a_ovf_at_max: assert property (p_ovf_at_max) else $error("no overflow at max");

   property p_dual_turn;
      MODES_DUAL[mode] && dir_ff == DIR_UP && cnt_ff == top && !wr_en
         |=> dir_ff == DIR_DOWN && cnt_ff == $past(cnt_ff) - CNT_STEP ##1 dir_ff == DIR_DOWN;
   endproperty
   a_dual_turn: assert property (p_dual_turn) else $error("dual slope did not turn");

   property p_fast_top;
      mode == 4'd5 && cnt_ff == TOP_8BIT && !wr_en |=> cnt_ff == BOTTOM && ovf_ff;
   endproperty
   a_fast_top: assert property (p_fast_top) else $error("fast pwm top wrong");

   property p_nonpwm_toggle;
      MODES_NONPWM[mode] && ctrl_a_ff.act_a == 2'b01 && match_a
         |=> chan_a_wave_output != $past(chan_a_wave_output);
   endproperty
   a_nonpwm_toggle: assert property (p_nonpwm_toggle) else $error("no toggle");

   property p_dual_clear_up;
      MODES_DUAL[mode] && ctrl_a_ff.act_a == 2'b10 && match_a && dir_ff == DIR_UP
         |=> !chan_a_wave_output;
   endproperty
   a_dual_clear_up: assert property (p_dual_clear_up) else $error("not cleared up");

   property p_top_act;
      MODES_FAST[mode] && ctrl_a_ff.act_a[1] && at_top
         |=> chan_a_wave_output != $past(ctrl_a_ff.act_a[0]);
   endproperty
   a_top_act: assert property (p_top_act) else $error("no top action");

   property p_fast_clr;
      MODES_FAST[mode] && ctrl_a_ff.act_a == 2'b10 && match_a && !at_top |=> !chan_a_wave_output;
   endproperty
   a_fast_clr: assert property (p_fast_clr) else $error("no clear on match");

   property p_dual_set_down;
      MODES_DUAL[mode] && ctrl_a_ff.act_a == 2'b10 && match_a && dir_ff == DIR_DOWN
         |=> chan_a_wave_output;
   endproperty
   a_dual_set_down: assert property (p_dual_set_down) else $error("not set down");

   property p_b_no_toggle;
      !MODES_NONPWM[mode] && ctrl_a_ff.act_b == ACT_TOGGLE |=> !chan_b_wave_oe;
   endproperty
   a_b_no_toggle: assert property (p_b_no_toggle) else $error("b toggles");

   property p_dual_ovf;
      MODES_DUAL[mode] && dir_ff == DIR_DOWN && cnt_ff == BOTTOM |=> ovf_ff;
   endproperty
   a_dual_ovf: assert property (p_dual_ovf) else $error("no bottom overflow");

   property p_bottom_reload;
      MODES_RELOAD_BOTTOM[mode] && dir_ff == DIR_DOWN && cnt_ff == BOTTOM
         |=> cmp_a_ff == $past(cmp_a_buf_ff);
   endproperty
   a_bottom_reload: assert property (p_bottom_reload) else $error("no bottom reload");

   property p_bottom_turn;
      MODES_DUAL[mode] && dir_ff == DIR_DOWN && cnt_ff == BOTTOM && !wr_en
         |=> dir_ff == DIR_UP && cnt_ff == CNT_STEP;
   endproperty
   a_bottom_turn: assert property (p_bottom_turn) else $error("no turn at bottom");
endmodule
`default_nettype wire

// >>> sim/port_pin_model.sv
// port pin model: resolves the two compare pins seen by the board
`timescale 1ns/1ns
`default_nettype none
module port_pin_model (
   // compare drive from the block
   input wire logic out_a,
   input wire logic oe_a,
   input wire logic out_b,
   input wire logic oe_b,
   // resolved pin levels
   output logic pin_a,
   output logic pin_b
);
   // ------
   // pin resolution
   // ------
   // an undriven pin falls back to its pull-up level
   assign pin_a = oe_a ? out_a : 1'b1;
   assign pin_b = oe_b ? out_b : 1'b1;
endmodule
`default_nettype wire

// >>> sim/timer16_waveform_mode_control_test.sv
// self-checking bench for the timer16 waveform mode control block
`timescale 1ns/1ns
`default_nettype none
module timer16_waveform_mode_control_test;
   import timer16_pkg::*;
   // bus and pin signals
   logic pclk = 1'b0;
   logic presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic out_a, oe_a, out_b, oe_b, pin_a, pin_b;
   int miscompares, checked, n;
   // ------
   // design and pin model
   // ------
   timer16_waveform_mode_control dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .chan_a_wave_output(out_a), .chan_a_wave_oe(oe_a),
      .chan_b_wave_output(out_b), .chan_b_wave_oe(oe_b));
   port_pin_model pins (.out_a(out_a), .oe_a(oe_a), .out_b(out_b), .oe_b(oe_b),
      .pin_a(pin_a), .pin_b(pin_b));
   // 100 MHz clock
   always #5 pclk = ~pclk;
   // ------
   // shared tasks
   // ------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // one apb transfer, held until pready is seen
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      check("apb wait", k, 32'h0000_0002);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // set mode, compare a, capture, both pins output, restart count
   task automatic cfg(input logic [7:0] cb, input logic [7:0] ca, input logic [15:0] ta,
         input logic [15:0] cap);
      apb(1'b1, OFS_CTRL_A, 32'h0000_0000);
      apb(1'b1, OFS_CAPTURE, {16'h0000, cap});
      apb(1'b1, OFS_CMP_A, {16'h0000, ta});
      apb(1'b1, OFS_CTRL_B, {24'h00_0000, cb});
      apb(1'b1, OFS_CTRL_A, {24'h00_0000, ca});
      apb(1'b1, OFS_PIN_DIR, 32'h0000_0003);
      apb(1'b1, OFS_COUNT, 32'h0000_0000);
      repeat (600) @(posedge pclk);
   endtask
   // length of the next whole run of pin a at level lvl
   task automatic run_len(input logic lvl);
      int k;
      k = 0;
      n = 0;
      #1;
      while (pin_a === lvl && k < 2000) begin
         @(posedge pclk);
         #1;
         k++;
      end
      while (pin_a !== lvl && k < 4000) begin
         @(posedge pclk);
         #1;
         k++;
      end
      while (pin_a === lvl && n < 2000) begin
         @(posedge pclk);
         #1;
         n++;
      end
   endtask
   // cycles out of 300 with pin a low
   task automatic low_count();
      n = 0;
      repeat (300) begin
         @(posedge pclk);
         #1;
         if (pin_a !== 1'b1) n++;
      end
   endtask
   // overflow flag: cleared, then set once the count reaches its event point
   task automatic ovf(input logic [7:0] cb, input logic [7:0] ca, input logic [15:0] start,
         input int wt);
      cfg(cb, ca, 16'h0040, 16'h0000);
      apb(1'b1, OFS_COUNT, {16'h0000, start});
      apb(1'b1, OFS_STATUS, 32'h0000_0001);
      apb(1'b0, OFS_STATUS, 32'h0000_0000);
      check("overflow early", 32'(rd[STAT_OVF_BIT]), 32'h0000_0000);
      repeat (wt) @(posedge pclk);
      apb(1'b0, OFS_STATUS, 32'h0000_0000);
      check("overflow late", 32'(rd[STAT_OVF_BIT]), 32'h0000_0001);
   endtask
   // ------
   // scenarios
   // ------
   task automatic t_regs();
      check("oe_a at reset", 32'(oe_a), 32'h0000_0000);
      apb(1'b0, OFS_CTRL_A, 32'h0000_0000);
      check("ctrl_a reset", rd, 32'h0000_0000);
      apb(1'b1, OFS_CTRL_A, 32'hFFFF_FFFF);
      apb(1'b0, OFS_CTRL_A, 32'h0000_0000);
      check("ctrl_a fields", rd, 32'h0000_00F3);
      apb(1'b1, OFS_CTRL_B, 32'hFFFF_FFFF);
      apb(1'b0, OFS_CTRL_B, 32'h0000_0000);
      check("ctrl_b fields", rd, 32'h0000_0018);
      apb(1'b0, 8'h40, 32'h0000_0000);
      check("unmapped err", 32'(err), 32'h0000_0001);
      check("unmapped data", rd, 32'h0000_0000);
      $display("test regs done");
   endtask
   task automatic t_nonpwm();
      logic [1:0] a;
      for (int i = 0; i < 4; i++) begin
         a = 2'(i);
         cfg(8'h08, {a, 6'h00}, 16'h0009, 16'h0000);
         check("ctc oe_a", 32'(oe_a), 32'(a != 2'b00));
         if (a == ACT_TOGGLE) begin
            run_len(1'b1);
            check("ctc toggle run", n, 32'h0000_000A);
         end else if (a != 2'b00) begin
            low_count();
            check("ctc level lows", n, a[0] ? 32'h0000_0000 : 32'h0000_012C);
         end
      end
      cfg(8'h18, 8'h40, 16'h0009, 16'h0013);
      run_len(1'b1);
      check("capture top run", n, 32'h0000_0014);
      apb(1'b1, OFS_PIN_DIR, 32'h0000_0000);
      repeat (3) @(posedge pclk);
      #1;
      check("oe_a pin input", 32'(oe_a), 32'h0000_0000);
      $display("test non-pwm done");
   endtask
   task automatic t_fast();
      cfg(8'h08, 8'h81, 16'h0040, 16'h0000);
      run_len(1'b1);
      check("fast high run", n, 32'h0000_0041);
      run_len(1'b0);
      check("fast low run", n, 32'h0000_00BF);
      cfg(8'h08, 8'hC1, 16'h0040, 16'h0000);
      run_len(1'b0);
      check("fast inverted low run", n, 32'h0000_0041);
      cfg(8'h08, 8'h81, 16'h00FF, 16'h0000);
      low_count();
      check("compare at top lows", n, 32'h0000_0000);
      cfg(8'h08, 8'h41, 16'h0040, 16'h0000);
      check("fast toggle oe_a", 32'(oe_a), 32'h0000_0000);
      cfg(8'h18, 8'h53, 16'h000F, 16'h0000);
      check("fast toggle oe_b", 32'(oe_b), 32'h0000_0000);
      run_len(1'b1);
      check("fast toggle run", n, 32'h0000_0010);
      apb(1'b1, OFS_CMP_B, 32'h0000_0020);
      cfg(8'h08, 8'h21, 16'h0040, 16'h0000);
      check("fast oe_b", 32'(oe_b), 32'h0000_0001);
      n = 0;
      repeat (256) begin
         @(posedge pclk);
         #1;
         if (pin_b !== 1'b1) n++;
      end
      check("fast b lows", n, 32'h0000_00DF);
      $display("test fast pwm done");
   endtask
   task automatic t_dual();
      cfg(8'h00, 8'h81, 16'h0040, 16'h0000);
      run_len(1'b0);
      check("dual low run", n, 32'h0000_017E);
      run_len(1'b1);
      check("dual high run", n, 32'h0000_0080);
      cfg(8'h00, 8'hC1, 16'h0040, 16'h0000);
      run_len(1'b1);
      check("dual inverted high run", n, 32'h0000_017E);
      cfg(8'h00, 8'h41, 16'h0040, 16'h0000);
      check("dual toggle oe_a", 32'(oe_a), 32'h0000_0000);
      cfg(8'h10, 8'h80, 16'h0010, 16'h0020);
      run_len(1'b0);
      check("capture dual low run", n, 32'h0000_0020);
      cfg(8'h10, 8'h43, 16'h000F, 16'h0000);
      run_len(1'b1);
      check("dual toggle run", n, 32'h0000_001E);
      $display("test dual slope done");
   endtask
   task automatic t_ovf();
      ovf(8'h00, 8'h00, 16'hFFE0, 60);
      ovf(8'h08, 8'h01, 16'h0010, 300);
      ovf(8'h00, 8'h01, 16'h0080, 600);
      $display("test overflow done");
   endtask
   // ------
   // verdict
   // ------
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      miscompares = 0;
      checked = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_nonpwm();
      t_fast();
      t_dual();
      t_ovf();
      finish_test();
   end
   // watchdog against a hung handshake
   initial begin
      #500_000;
      miscompares++;
      finish_test();
   end
endmodule
`default_nettype wire
